// [hw/adr_device.sv]
`timescale 1ns/1ns
module adr_device import adr_pkg::*; #(
  parameter bit HAS_CURRENT_SENSE = 1'b1,
  parameter int WAKE_INPUTS = ADR_WAKE_INPUTS_FULL,
  parameter logic [1:0] FULL_REV = 2'h0,
  parameter logic [1:0] MINOR_REV = 2'h0
) (
  // System
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register link
  adr_link_if.dev link,
  // Analog front end
  input wire logic [5:0] wake_input,
  input wire logic [5:0] wake_event,
  input wire logic [1:0] other_wake_event,
  input wire logic conv_valid,
  input wire logic [3:0] conv_channel,
  input wire logic [9:0] conv_value,
  // Controls to analog
  output logic [7:0] current_sense_out,
  output logic [15:0] conv_select_out,
  output logic [7:0] wake_input_ctrl_out,
  output logic [7:0] wake_up_ctrl_out
);
  // Only the full and the reduced build are served
  if (WAKE_INPUTS != ADR_WAKE_INPUTS_FULL &&
      WAKE_INPUTS != ADR_WAKE_INPUTS_REDUCED) begin : g_bad_wake
    $error("adr_device: unsupported WAKE_INPUTS");
  end

  // Present wake inputs, and all converter channels present in this build
  localparam logic [5:0] WAKE_PRESENT = 6'((1 << WAKE_INPUTS) - 1);
  wire logic [15:0] ch_present;
  assign ch_present =
    ~({10'h000, ~WAKE_PRESENT} << ADR_WAKE_CH_FIRST)
    & ~(HAS_CURRENT_SENSE ? 16'h0000 : 16'h0200)
    & ~(16'h0001 << ADR_UNUSED_CH);

  logic [7:0] current_sense;
  logic [15:0] conv_select;
  logic [15:0] conv_done;
  logic [7:0] wake_in_ctrl;
  logic [7:0] wake_up_ctrl;
  logic [7:0] wake_src;
  logic [9:0] result [ADR_CHANNELS];
  logic [7:0] rdata;
  logic ack;
  logic err;

  // Accept either window; the low byte is the register offset
  wire logic [7:0] off;
  wire logic in_window;
  assign off = link.addr[7:0];
  assign in_window = (link.addr[15:8] == ADR_BASE_BLOCKING[15:8]) ||
    (link.addr[15:8] == ADR_BASE_NONBLOCKING[15:8]);
  wire logic rd_hit;
  wire logic wr_hit;
  wire logic is_result;
  wire logic [3:0] res_idx;
  // Channel c reads at RESULT_FIRST + 2c, high byte at the even offset
  assign is_result = (off >= ADR_OFF_RESULT_FIRST) &&
    (off <= ADR_OFF_RESULT_LAST);
  assign res_idx = 4'((off - ADR_OFF_RESULT_FIRST) >> 1);

  function automatic logic known(input logic [7:0] o);
    known = (o == ADR_OFF_WAKE_LEVEL) || (o == ADR_OFF_WAKE_INPUT_CTRL) ||
      (o == ADR_OFF_WAKE_UP_CTRL) || (o == ADR_OFF_WAKE_SOURCE) ||
      (o == ADR_OFF_CURRENT_SENSE) || (o == ADR_OFF_CONV_SEL_HI) ||
      (o == ADR_OFF_CONV_SEL_LO) || (o == ADR_OFF_CONV_DONE_HI) ||
      (o == ADR_OFF_CONV_DONE_LO) || (o == ADR_OFF_SILICON_REV);
  endfunction

  assign rd_hit = in_window && (known(off) || is_result);
  assign wr_hit = link.req && link.wr && in_window;

  // Read mux
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (is_result) begin
      if (!off[0])
        next_rdata = result[res_idx][9:2];
      else
        next_rdata = {result[res_idx][1:0], 6'h00};
    end else begin
      case (off)
        ADR_OFF_WAKE_LEVEL: next_rdata = {2'h0, wake_input & WAKE_PRESENT};
        ADR_OFF_WAKE_INPUT_CTRL: next_rdata = wake_in_ctrl;
        ADR_OFF_WAKE_UP_CTRL: next_rdata = wake_up_ctrl;
        ADR_OFF_WAKE_SOURCE: next_rdata = wake_src;
        ADR_OFF_CURRENT_SENSE: next_rdata = current_sense;
        ADR_OFF_CONV_SEL_HI: next_rdata = conv_select[15:8];
        ADR_OFF_CONV_SEL_LO: next_rdata = conv_select[7:0];
        ADR_OFF_CONV_DONE_HI: next_rdata = conv_done[15:8];
        ADR_OFF_CONV_DONE_LO: next_rdata = conv_done[7:0];
        ADR_OFF_SILICON_REV:
          next_rdata = {4'h0, FULL_REV, MINOR_REV};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Absent functions keep their control bits at zero regardless of host
  wire logic [7:0] wake_mask8;
  assign wake_mask8 = {2'h0, WAKE_PRESENT};
  wire logic rd_done_hi;
  wire logic rd_done_lo;
  wire logic rd_src;
  assign rd_done_hi = link.req && !link.wr && in_window &&
    off == ADR_OFF_CONV_DONE_HI;
  assign rd_done_lo = link.req && !link.wr && in_window &&
    off == ADR_OFF_CONV_DONE_LO;
  assign rd_src = link.req && !link.wr && in_window &&
    off == ADR_OFF_WAKE_SOURCE;

  wire logic [15:0] conv_set;
  assign conv_set = (conv_valid ? 16'(1) << conv_channel : 16'h0000)
    & ch_present;
  wire logic [7:0] src_set;
  assign src_set = {other_wake_event, wake_event & WAKE_PRESENT
    & wake_up_ctrl[5:0]};

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      current_sense <= ADR_RST_CURRENT_SENSE;
      conv_select <= 16'h0000;
      wake_in_ctrl <= ADR_RST_ZERO;
      wake_up_ctrl <= ADR_RST_ZERO;
    end else if (wr_hit) begin
      case (off)
        ADR_OFF_CURRENT_SENSE:
          current_sense <= HAS_CURRENT_SENSE ? link.wdata : 8'h00;
        ADR_OFF_CONV_SEL_HI:
          conv_select[15:8] <= link.wdata & ch_present[15:8];
        ADR_OFF_CONV_SEL_LO:
          conv_select[7:0] <= link.wdata & ch_present[7:0];
        ADR_OFF_WAKE_INPUT_CTRL: wake_in_ctrl <= link.wdata & wake_mask8;
        ADR_OFF_WAKE_UP_CTRL:
          wake_up_ctrl <= link.wdata & (wake_mask8 | ADR_WAKE_UP_FIXED_MASK);
        // Revision and status offsets take no write
        default: ;
      endcase
    end
  end

  // Set wins over the clear-on-read
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      conv_done <= 16'h0000;
      wake_src <= 8'h00;
    end else begin
      conv_done[15:8] <= (rd_done_hi ? 8'h00 : conv_done[15:8]) |
        conv_set[15:8];
      conv_done[7:0] <= (rd_done_lo ? 8'h00 : conv_done[7:0]) |
        conv_set[7:0];
      wake_src <= (rd_src ? 8'h00 : wake_src) | src_set;
    end
  end

  for (genvar c = 0; c < ADR_CHANNELS; c++) begin : g_res
    always_ff @(posedge clk_sys) begin
      if (sys_rst)
        result[c] <= 10'h000;
      else if (conv_set[c])
        result[c] <= conv_value;
    end
  end

  // One-cycle answer; unmapped offsets read zero and flag an error
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata <= 8'h00;
      ack <= 1'b0;
      err <= 1'b0;
    end else begin
      rdata <= (link.req && !link.wr) ? next_rdata : 8'h00;
      ack <= link.req;
      err <= link.req && !(link.wr ? (in_window && known(off)) : rd_hit);
    end
  end

  assign link.rdata = rdata;
  assign link.ack = ack;
  assign link.err = err;
  assign current_sense_out = current_sense;
  assign conv_select_out = conv_select;
  assign wake_input_ctrl_out = wake_in_ctrl;
  assign wake_up_ctrl_out = wake_up_ctrl;
endmodule

// [hw/adr_host.sv]
`timescale 1ns/1ns
module adr_host import adr_pkg::*; #(
  parameter bit HAS_CURRENT_SENSE = 1'b1,
  parameter int WAKE_INPUTS = ADR_WAKE_INPUTS_FULL
) (
  // System
  input wire logic clk_sys,
  input wire logic sys_rst,
  // User command
  input wire logic cmd_valid,
  input wire logic cmd_wr,
  input wire logic cmd_nonblocking,
  input wire logic [7:0] cmd_offset,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_err,
  // Register link
  adr_link_if.host link
);
  if (WAKE_INPUTS != ADR_WAKE_INPUTS_FULL &&
      WAKE_INPUTS != ADR_WAKE_INPUTS_REDUCED) begin : g_bad_wake
    $error("adr_host: unsupported WAKE_INPUTS");
  end

  localparam logic [7:0] WAKE_MASK = 8'((1 << WAKE_INPUTS) - 1);
  localparam logic [15:0] CH_OK =
    ~({10'h000, ~WAKE_MASK[5:0]} << ADR_WAKE_CH_FIRST)
    & ~(HAS_CURRENT_SENSE ? 16'h0000 : 16'h0200);

  typedef enum logic [1:0] {
    ADR_IDLE = 2'b01,
    ADR_WAIT = 2'b10
  } adr_state_t;
  adr_state_t state;

  logic req;
  logic wr;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rsp_data;
  logic rsp_v;
  logic rsp_e;
  logic [7:0] off_q;

  // Write data made safe for absent functions
  logic [7:0] safe_wdata;
  always_comb begin
    case (cmd_offset)
      ADR_OFF_CURRENT_SENSE:
        safe_wdata = HAS_CURRENT_SENSE ? cmd_wdata : ADR_RST_CURRENT_SENSE;
      ADR_OFF_CONV_SEL_HI:
        safe_wdata = cmd_wdata & CH_OK[15:8];
      ADR_OFF_CONV_SEL_LO: safe_wdata = cmd_wdata & CH_OK[7:0];
      ADR_OFF_WAKE_INPUT_CTRL:
        safe_wdata = cmd_wdata & WAKE_MASK;
      ADR_OFF_WAKE_UP_CTRL:
        safe_wdata = cmd_wdata & (WAKE_MASK | ADR_WAKE_UP_FIXED_MASK);
      default: safe_wdata = cmd_wdata;
    endcase
  end

  // Read data with absent bits hidden from the user
  logic [7:0] rd_mask;
  always_comb begin
    if (off_q >= ADR_OFF_RESULT_FIRST && off_q <= ADR_OFF_RESULT_LAST)
      rd_mask = CH_OK[4'((off_q - ADR_OFF_RESULT_FIRST) >> 1)] ? 8'hff
        : 8'h00;
    else begin
      case (off_q)
        ADR_OFF_WAKE_LEVEL: rd_mask = WAKE_MASK;
        ADR_OFF_WAKE_SOURCE:
          rd_mask = WAKE_MASK | ADR_WAKE_UP_FIXED_MASK;
        ADR_OFF_CONV_DONE_HI: rd_mask = CH_OK[15:8];
        ADR_OFF_CONV_DONE_LO: rd_mask = CH_OK[7:0];
        default: rd_mask = 8'hff;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= ADR_IDLE;
      req <= 1'b0;
      wr <= 1'b0;
      addr <= 16'h0000;
      wdata <= 8'h00;
      off_q <= 8'h00;
      rsp_v <= 1'b0;
      rsp_data <= 8'h00;
      rsp_e <= 1'b0;
    end else begin
      rsp_v <= 1'b0;
      case (state)
        ADR_IDLE: begin
          if (cmd_valid) begin
            req <= 1'b1;
            wr <= cmd_wr;
            addr <= (cmd_nonblocking ? ADR_BASE_NONBLOCKING
              : ADR_BASE_BLOCKING) | {8'h00, cmd_offset};
            wdata <= safe_wdata;
            off_q <= cmd_offset;
            state <= ADR_WAIT;
          end
        end
        ADR_WAIT: begin
          req <= 1'b0;
          if (link.ack) begin
            rsp_v <= 1'b1;
            rsp_data <= link.rdata & rd_mask;
            rsp_e <= link.err;
            state <= ADR_IDLE;
          end
        end
        default: state <= ADR_IDLE;
      endcase
    end
  end

  assign cmd_ready = (state == ADR_IDLE);
  assign rsp_valid = rsp_v;
  assign rsp_rdata = rsp_data;
  assign rsp_err = rsp_e;
  assign link.req = req;
  assign link.wr = wr;
  assign link.addr = addr;
  assign link.wdata = wdata;
endmodule

// [hw/adr_link_if.sv]
`timescale 1ns/1ns
interface adr_link_if;
  logic req;
  logic wr;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  logic err;
  modport dev (input req, input wr, input addr, input wdata,
    output rdata, output ack, output err);
  modport host (output req, output wr, output addr, output wdata,
    input rdata, input ack, input err);
endinterface

// [hw/adr_pkg.sv]
package adr_pkg;
  localparam logic [15:0] ADR_BASE_BLOCKING = 16'h0200;
  localparam logic [15:0] ADR_BASE_NONBLOCKING = 16'h0300;
  localparam logic [7:0] ADR_OFF_WAKE_LEVEL = 8'h08;
  localparam logic [7:0] ADR_OFF_WAKE_INPUT_CTRL = 8'h09;
  localparam logic [7:0] ADR_OFF_WAKE_UP_CTRL = 8'h12;
  localparam logic [7:0] ADR_OFF_WAKE_SOURCE = 8'h14;
  localparam logic [7:0] ADR_OFF_CURRENT_SENSE = 8'h3c;
  localparam logic [7:0] ADR_OFF_CONV_SEL_HI = 8'h82;
  localparam logic [7:0] ADR_OFF_CONV_SEL_LO = 8'h83;
  localparam logic [7:0] ADR_OFF_CONV_DONE_HI = 8'h84;
  localparam logic [7:0] ADR_OFF_CONV_DONE_LO = 8'h85;
  localparam logic [7:0] ADR_OFF_RESULT_FIRST = 8'h86;
  localparam logic [7:0] ADR_OFF_RESULT_LAST = 8'ha5;
  localparam logic [7:0] ADR_OFF_CH9_RESULT_HI = 8'h98;
  localparam logic [7:0] ADR_OFF_CH9_RESULT_LO = 8'h99;
  localparam logic [7:0] ADR_OFF_SILICON_REV = 8'hf4;
  localparam logic [7:0] ADR_RST_CURRENT_SENSE = 8'h00;
  localparam logic [7:0] ADR_RST_ZERO = 8'h00;
  localparam int ADR_FULL_REV_MSB = 3;
  localparam int ADR_FULL_REV_LSB = 2;
  localparam int ADR_MINOR_REV_MSB = 1;
  localparam int ADR_MINOR_REV_LSB = 0;
  localparam int ADR_CURRENT_CH = 9;
  localparam int ADR_WAKE_CH_FIRST = 3;
  localparam int ADR_WAKE_INPUTS_FULL = 6;
  localparam int ADR_WAKE_INPUTS_REDUCED = 4;
  localparam int ADR_CHANNELS = 16;
  localparam int ADR_UNUSED_CH = 13;
  localparam logic [7:0] ADR_WAKE_UP_FIXED_MASK = 8'hc0;
endpackage

// [testbench/adr_link_properties.sv]
`timescale 1ns/1ns
module adr_link_properties import adr_pkg::*; #(
  parameter logic [1:0] FULL_REV = 2'h0,
  parameter logic [1:0] MINOR_REV = 2'h0
) (
  // System
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register link
  input wire logic req,
  input wire logic wr,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack,
  input wire logic err
);
  // Written for the reduced build: no current sense, wake inputs 0 to 3
  wire logic [7:0] off = addr[7:0];
  wire logic blk_win = addr[15:8] == ADR_BASE_BLOCKING[15:8];
  wire logic nb_win = addr[15:8] == ADR_BASE_NONBLOCKING[15:8];
  wire logic rd_req = req && !wr && (blk_win || nb_win);
  wire logic wr_req = req && wr && (blk_win || nb_win);
  wire logic ch9_off = off == ADR_OFF_CH9_RESULT_HI ||
    off == ADR_OFF_CH9_RESULT_LO;
  wire logic wake_off = off == ADR_OFF_WAKE_INPUT_CTRL ||
    off == ADR_OFF_WAKE_UP_CTRL;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_ack_next_cycle: assert property (req |=> ack)
    else $error("request not answered on the next cycle");
  a_ack_has_cause: assert property (ack |-> $past(req))
    else $error("answer without a request");
  a_unmapped_err: assert property (rd_req && off == 8'hf0
    |=> err && rdata == 8'h00) else $error("unmapped read not refused");
  a_rev_full: assert property (rd_req
    && off == ADR_OFF_SILICON_REV
    |=> rdata[3:2] == FULL_REV && !err) else $error("full revision wrong");
  a_rev_minor: assert property (rd_req
    && off == ADR_OFF_SILICON_REV
    |=> rdata[1:0] == MINOR_REV) else $error("minor revision wrong");
  a_rev_upper_zero: assert property (rd_req
    && off == ADR_OFF_SILICON_REV
    |=> rdata[7:4] == 4'h0) else $error("revision upper bits set");
  a_result_low_pad: assert property (rd_req && off[0]
    && off > ADR_OFF_RESULT_FIRST && off <= ADR_OFF_RESULT_LAST
    |=> rdata[5:0] == 6'h00) else $error("result pad set");
  a_ch9_absent: assert property (rd_req && ch9_off
    |=> rdata == 8'h00)
    else $error("channel 9 result present");
  a_cs_write_zero: assert property (wr_req
    && off == ADR_OFF_CURRENT_SENSE |-> wdata == ADR_RST_CURRENT_SENSE)
    else $error("current sense written non-zero");
  a_sel_absent_zero: assert property (wr_req
    && off == ADR_OFF_CONV_SEL_HI |-> wdata[1:0] == 2'b00)
    else $error("absent channel selected");
  a_wake_absent_zero: assert property (wr_req
    && wake_off
    |-> wdata[5:4] == 2'b00) else $error("absent wake input written");
  a_wake_level_mask: assert property (rd_req
    && off == ADR_OFF_WAKE_LEVEL |=> rdata[7:4] == 4'h0)
    else $error("absent wake level bits set");
  a_sel_lo_absent: assert property (wr_req
    && off == ADR_OFF_CONV_SEL_LO |-> !wdata[7])
    else $error("absent wake channel selected in low byte");
  a_wake_ch_absent: assert property (rd_req
    && off >= ADR_OFF_RESULT_FIRST + 8'h0e
    && off <= ADR_OFF_RESULT_FIRST + 8'h11 |=> rdata == 8'h00)
    else $error("absent wake channel result present");
endmodule

// [testbench/analog_die_option_and_revision_regs_tb_top.sv]
`timescale 1ns/1ns
module analog_die_option_and_revision_regs_tb_top import adr_pkg::*;;
  localparam logic [1:0] FULL_REV = 2'h2;
  localparam logic [1:0] MINOR_REV = 2'h1;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_wr = 1'b0;
  logic cmd_nb = 1'b0;
  logic [7:0] cmd_offset = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_ready, rsp_valid, rsp_err;
  logic [7:0] rsp_rdata, rd, cs_out, wi_out, wu_out;
  logic [15:0] sel_out;
  logic [5:0] wake_input = 6'h00;
  logic [5:0] wake_event = 6'h00;
  logic [1:0] other_wake_event = 2'h0;
  logic conv_valid = 1'b0;
  logic [3:0] conv_channel = 4'h0;
  logic [9:0] conv_value = 10'h000;
  logic [3:0] chs [5] = '{4'h2, 4'h6, 4'ha, 4'hc, 4'hf};
  int miscompares = 0;
  int checks = 0;

  adr_link_if link ();
  adr_host #(.HAS_CURRENT_SENSE(1'b0), .WAKE_INPUTS(ADR_WAKE_INPUTS_REDUCED))
    adr_host_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_wr(cmd_wr), .cmd_nonblocking(cmd_nb),
    .cmd_offset(cmd_offset), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err),
    .link(link.host));
  adr_device #(.HAS_CURRENT_SENSE(1'b0), .FULL_REV(FULL_REV),
    .WAKE_INPUTS(ADR_WAKE_INPUTS_REDUCED), .MINOR_REV(MINOR_REV))
    adr_device_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link.dev),
    .wake_input(wake_input), .wake_event(wake_event),
    .other_wake_event(other_wake_event), .conv_valid(conv_valid),
    .conv_channel(conv_channel), .conv_value(conv_value),
    .current_sense_out(cs_out), .conv_select_out(sel_out),
    .wake_input_ctrl_out(wi_out), .wake_up_ctrl_out(wu_out));
  adr_link_properties #(.FULL_REV(FULL_REV), .MINOR_REV(MINOR_REV))
    adr_link_properties_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .req(link.req), .wr(link.wr), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata), .ack(link.ack), .err(link.err));

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp,
      input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Either window is drawn at random for every command
  task automatic cmd(input logic w, input logic [7:0] off,
      input logic [7:0] d, input logic exp_err);
    int n = 0;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_wr <= w;
    cmd_nb <= 1'($urandom_range(1, 0));
    cmd_offset <= off;
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (rsp_valid !== 1'b1 && n < 8);
    rd = rsp_rdata;
    chk("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
    chk("cmd_ready", 16'h0001, {15'h0000, cmd_ready});
    chk("rsp_err", {15'h0000, exp_err}, {15'h0000, rsp_err});
  endtask

  task automatic rdchk(input string name, input logic [7:0] off,
      input logic [7:0] exp);
    cmd(1'b0, off, 8'h00, 1'b0);
    chk(name, {8'h00, exp}, {8'h00, rd});
  endtask

  task automatic conv(input logic [3:0] ch, input logic [9:0] v);
    @(posedge clk_sys);
    conv_valid <= 1'b1;
    conv_channel <= ch;
    conv_value <= v;
    @(posedge clk_sys);
    conv_valid <= 1'b0;
  endtask

  initial begin
    logic [7:0] w;
    logic [9:0] v;
    logic [7:0] ro;
    logic [15:0] done_exp;
    void'($urandom(32'h1560));
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    ro = {4'h0, FULL_REV, MINOR_REV};
    rdchk("revision", ADR_OFF_SILICON_REV, ro);
    cmd(1'b1, ADR_OFF_SILICON_REV, 8'hff, 1'b0);
    rdchk("revision_after_write", ADR_OFF_SILICON_REV, ro);
    cmd(1'b0, 8'hf0, 8'h00, 1'b1);
    chk("unmapped", 16'h0000, {8'h00, rd});
    done_exp = 16'h0000;
    for (int i = 0; i < 5; i++) begin
      w = (i == 0) ? 8'hff : 8'($urandom);
      v = (i == 0) ? 10'h3ff : 10'($urandom);
      cmd(1'b1, ADR_OFF_CURRENT_SENSE, w, 1'b0);
      rdchk("current_sense", ADR_OFF_CURRENT_SENSE, 8'h00);
      chk("cs_out", 16'h0000, {8'h00, cs_out});
      cmd(1'b1, ADR_OFF_CONV_SEL_HI, w, 1'b0);
      cmd(1'b1, ADR_OFF_CONV_SEL_LO, w, 1'b0);
      chk("sel_out", {w & 8'hdc, w & 8'h7f}, sel_out);
      cmd(1'b1, ADR_OFF_WAKE_INPUT_CTRL, w, 1'b0);
      chk("wi_out", {8'h00, w & 8'h0f}, {8'h00, wi_out});
      rdchk("wake_ctrl", ADR_OFF_WAKE_INPUT_CTRL, w & 8'h0f);
      cmd(1'b1, ADR_OFF_WAKE_UP_CTRL, w, 1'b0);
      chk("wake_up", 16'(w[3:0]), 16'(wu_out[5:0]));
      @(posedge clk_sys);
      wake_input <= w[5:0];
      // Give the new pin level a few cycles before reading it back
      repeat (3) @(posedge clk_sys);
      ro = {4'h0, w[3:0]};
      rdchk("wake_level", ADR_OFF_WAKE_LEVEL, ro);
      conv(chs[i], v);
      done_exp = done_exp | (16'h0001 << chs[i]);
      ro = ADR_OFF_RESULT_FIRST + {3'b000, chs[i], 1'b0};
      rdchk("result_hi", ro, v[9:2]);
      rdchk("result_lo", ro + 8'h01, {v[1:0], 6'h00});
    end
    conv(4'h7, 10'h3ff);
    ro = ADR_OFF_RESULT_FIRST + 8'h0e;
    rdchk("ch7_hi", ro, 8'h00);
    rdchk("ch7_lo", ro + 8'h01, 8'h00);
    conv(4'h9, 10'h3ff);
    rdchk("ch9_hi", ADR_OFF_CH9_RESULT_HI, 8'h00);
    rdchk("ch9_lo", ADR_OFF_CH9_RESULT_LO, 8'h00);
    rdchk("done_hi", ADR_OFF_CONV_DONE_HI, done_exp[15:8]);
    rdchk("done_lo", ADR_OFF_CONV_DONE_LO, done_exp[7:0]);
    rdchk("done_clr", ADR_OFF_CONV_DONE_HI, 8'h00);
    cmd(1'b1, ADR_OFF_WAKE_UP_CTRL, 8'h0f, 1'b0);
    @(posedge clk_sys);
    wake_event <= 6'h3f;
    other_wake_event <= 2'b01;
    @(posedge clk_sys);
    wake_event <= 6'h00;
    other_wake_event <= 2'b00;
    rdchk("wake_source", ADR_OFF_WAKE_SOURCE, 8'h4f);
    rdchk("wake_source_clr", ADR_OFF_WAKE_SOURCE, 8'h00);
    conclude();
  end

  initial begin
    #(4 * 5000);
    miscompares++;
    conclude();
  end
endmodule
